// >>> include/bpi_pkg.sv
`default_nettype none
package bpi_pkg;
    localparam int BPI_DIGITS = 10;
    localparam int BPI_DW = 4;
    localparam logic [3:0] BPI_CODE_DP = 4'hA;
    localparam logic [3:0] BPI_CODE_EXP = 4'hB;
    localparam logic [3:0] BPI_CODE_ENTER = 4'hC;
    localparam logic [3:0] BPI_CODE_LABEL_A = 4'hD;
    localparam logic [3:0] BPI_CODE_SIGN = 4'hE;
    localparam logic [3:0] BPI_CODE_NOP = 4'hF;
    // register map
    localparam logic [7:0] BPI_OFS_CTRL = 8'h00;
    localparam logic [7:0] BPI_OFS_STAT = 8'h04;
    localparam logic [7:0] BPI_OFS_CMD = 8'h08;
    localparam logic [7:0] BPI_OFS_DIGIT = 8'h0C;
    localparam logic [31:0] BPI_CTRL_RST = 32'h0000_0000;
    localparam int BPI_CTRL_RUN_BIT = 0;
    localparam int BPI_CMD_OP_LSB = 0;
    localparam int BPI_CMD_FLAG_LSB = 4;
    localparam logic [1:0] BPI_RESP_OKAY = 2'b00;
    localparam logic [1:0] BPI_RESP_SLVERR = 2'b10;

    typedef enum logic [3:0] {
        BPI_K_NUM, BPI_K_DP, BPI_K_EXP, BPI_K_ENTER,
        BPI_K_LABEL_A, BPI_K_SIGN, BPI_K_NOP
    } bpi_kind_e;

    typedef struct packed {
        bpi_kind_e kind;
        logic [3:0] value;
    } bpi_token_s;

    // flag command opcodes written to CMD
    typedef enum logic [1:0] {
        BPI_OP_SET = 2'b01,
        BPI_OP_CLEAR = 2'b10,
        BPI_OP_TEST = 2'b11,
        BPI_OP_NONE = 2'b00
    } bpi_op_e;

    typedef enum logic [1:0] {
        BPI_ST_IDLE = 2'b00,
        BPI_ST_FULL = 2'b01,
        BPI_ST_HOLD = 2'b11
    } bpi_state_e;
endpackage : bpi_pkg
`default_nettype wire

// >>> rtl/bpi_decode.sv
`timescale 1ns/1ps
`default_nettype none
module bpi_decode
    import bpi_pkg::*;
(
    input wire logic [3:0] code_i,
    input wire logic true_mode_i,
    output var bpi_token_s token_o
);
    logic [3:0] code;

    always_comb begin
        code = true_mode_i ? code_i : ~code_i;
        token_o.value = code;
        unique case (code)
            BPI_CODE_DP: token_o.kind = BPI_K_DP;
            BPI_CODE_EXP: token_o.kind = BPI_K_EXP;
            BPI_CODE_ENTER: token_o.kind = BPI_K_ENTER;
            BPI_CODE_LABEL_A: token_o.kind = BPI_K_LABEL_A;
            BPI_CODE_SIGN: token_o.kind = BPI_K_SIGN;
            BPI_CODE_NOP: token_o.kind = BPI_K_NOP;
            default: token_o.kind = BPI_K_NUM;
        endcase
    end
endmodule : bpi_decode
`default_nettype wire

// >>> rtl/bpi_port.sv
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - forty data lines form ten independent 4-bit digits; any subset used.
// - codes 0-9 numerals, A point, B exponent, C enter, D label A, E sign, F no-op.
// - data polarity is selectable, positive-true or negative-true.
// - polarity input high keeps data true; low complements every bit first.
// - unconnected digits decode as no-op and add nothing; this design decodes pulled-up lines as numeral 0 in negative-true mode.
// - four flag outputs and input-ready, all active low.
// - flag output low while its flag is set, high when cleared.
// - flags clear at reset and clear command; set command sets; test clears 2,3.
// - flag 3 set by numeral, exponent or point from keyboard or port.
// - inhibit forces flag outputs inactive, internal flags untouched.
// - after re-enable, next flag-affecting instruction refreshes all outputs.
// - input-ready low means data may load; high means refused. This design also refuses loads while inhibited, with input-ready left low.
// - input-ready high while a program runs.
// - input-ready high while the input register holds unconsumed data.
// - input-ready high once flag 3 set and port delivered label A.
// - input-ready low only when register empty, flag 3 clear, halted.
// - input-ready low right after reset.
// - two load inputs of opposite polarity each start a load.
// - inhibit input defaults to inhibited when unconnected.
// - polarity input defaults to true mode when unconnected.
module bpi_port
    import bpi_pkg::*;
#(
    parameter int DIGITS = BPI_DIGITS
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [DIGITS*4-1:0] data_i,
    input wire logic true_mode_i,
    input wire logic load_i,
    input wire logic load_n_i,
    input wire logic inhibit_i,
    input wire logic key_entry_i,
    output logic flag_out_zero_n_o,
    output logic flag_out_one_n_o,
    output logic flag_out_two_n_o,
    output logic flag_out_three_n_o,
    output logic input_ready_n_o,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // pin synchronisers: data, polarity, loads, inhibit (first stage private)
    localparam int SW = DIGITS*4 + 4;
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic [DIGITS*4-1:0] data_s;
    logic true_s;
    logic load_s;
    logic load_n_s;
    logic inhibit_s;
    logic load_req;
    logic load_req_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // idle pin levels: no-op data, true mode, loads off, inhibited
            // so the load edge detector sees no false edge after reset
            sync1 <= {{DIGITS*4{1'b1}}, 4'hB};
            sync2 <= {{DIGITS*4{1'b1}}, 4'hB};
        end else begin
            sync1 <= {data_i, true_mode_i, load_i, load_n_i, inhibit_i};
            sync2 <= sync1;
        end
    end

    assign {data_s, true_s, load_s, load_n_s, inhibit_s} = sync2;
    assign load_req = load_s ^ ~load_n_s; // either line alone starts it

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_req_q <= 1'b0;
        end else begin
            load_req_q <= load_req;
        end
    end

    // per-digit decode
    bpi_token_s tok [DIGITS];
    genvar gi;
    generate
        for (gi = 0; gi < DIGITS; gi++) begin : g_dec
            bpi_decode u_dec (
                .code_i(data_s[(DIGITS-1-gi)*4 +: 4]), // digit 0 is MSD
                .true_mode_i(true_s),
                .token_o(tok[gi])
            );
        end
    endgenerate

    // input register
    bpi_token_s held [DIGITS];
    logic [3:0] rd_idx;
    bpi_state_e state;
    logic [3:0] flags;
    logic running;
    logic label_a_hold;
    logic consume;
    logic ready_cond;
    logic refresh;
    logic [3:0] flag_shown;
    logic refresh_q;
    logic load_start;

    assign ready_cond = (state == BPI_ST_IDLE) && !flags[3]
                        && !running && !label_a_hold;
    assign consume = (state == BPI_ST_FULL); // one digit per cycle
    // rising load request, accepted only while ready and enabled
    assign load_start = (state == BPI_ST_IDLE) && load_req && !load_req_q
                        && ready_cond && !inhibit_s;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= BPI_ST_IDLE;
            rd_idx <= 4'h0;
        end else begin
            unique case (state)
                BPI_ST_IDLE: begin
                    if (load_start) begin
                        state <= BPI_ST_FULL;
                        rd_idx <= 4'h0;
                    end
                end
                BPI_ST_FULL: begin
                    if (rd_idx == 4'(DIGITS-1)) begin
                        state <= BPI_ST_HOLD;
                    end
                    rd_idx <= rd_idx + 4'h1;
                end
                BPI_ST_HOLD: begin
                    state <= BPI_ST_IDLE; // all consumed
                end
                default: state <= BPI_ST_IDLE;
            endcase
        end
    end

    generate
        for (gi = 0; gi < DIGITS; gi++) begin : g_hold
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    held[gi] <= '{kind: BPI_K_NOP, value: BPI_CODE_NOP};
                end else if (load_start) begin
                    held[gi] <= tok[gi];
                end
            end
        end
    endgenerate

    // token under consumption
    bpi_token_s cur;
    logic port_data_entry;
    logic port_label_a;
    always_comb begin
        cur = held[rd_idx < 4'(DIGITS) ? rd_idx : 4'h0];
        port_data_entry = consume && (cur.kind == BPI_K_NUM
            || cur.kind == BPI_K_EXP || cur.kind == BPI_K_DP);
        port_label_a = consume && cur.kind == BPI_K_LABEL_A;
    end

    // software command register
    logic [1:0] cmd_op;
    logic [1:0] cmd_flag;
    logic cmd_stb;
    logic [31:0] ctrl;
    assign running = ctrl[BPI_CTRL_RUN_BIT];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags <= 4'h0;
        end else if (cmd_stb) begin
            unique case (bpi_op_e'(cmd_op))
                BPI_OP_SET: flags[cmd_flag] <= 1'b1;
                BPI_OP_CLEAR: flags[cmd_flag] <= 1'b0;
                BPI_OP_TEST: if (cmd_flag[1]) flags[cmd_flag] <= 1'b0;
                BPI_OP_NONE: ;
            endcase
            if (port_data_entry || key_entry_i) flags[3] <= 1'b1;
        end else if (port_data_entry || key_entry_i) begin
            flags[3] <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            label_a_hold <= 1'b0;
        end else if (port_label_a && flags[3]) begin
            label_a_hold <= 1'b1;
        end else if (!flags[3]) begin
            label_a_hold <= 1'b0;
        end
    end

    // outputs: inhibit blanks, re-enable waits for a flag instruction
    assign refresh = cmd_stb || port_data_entry || key_entry_i;
    // flags settle one edge after the instruction; copy them then
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            refresh_q <= 1'b0;
        end else begin
            refresh_q <= refresh;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_shown <= 4'h0;
        end else if (inhibit_s) begin
            flag_shown <= 4'h0;
        end else if (refresh_q) begin
            flag_shown <= flags;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            input_ready_n_o <= 1'b0;
            flag_out_zero_n_o <= 1'b1;
            flag_out_one_n_o <= 1'b1;
            flag_out_two_n_o <= 1'b1;
            flag_out_three_n_o <= 1'b1;
        end else begin
            input_ready_n_o <= !ready_cond;
            flag_out_zero_n_o <= !flag_shown[0];
            flag_out_one_n_o <= !flag_shown[1];
            flag_out_two_n_o <= !flag_shown[2];
            flag_out_three_n_o <= !flag_shown[3];
        end
    end

    // axi4-lite slave
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    assign s_axi_awready = !aw_got && !s_axi_bvalid;
    assign s_axi_wready = !w_got && !s_axi_bvalid;
    assign cmd_stb = aw_got && w_got && !s_axi_bvalid
                     && aw_addr == BPI_OFS_CMD;
    assign cmd_op = w_data[BPI_CMD_OP_LSB +: 2];
    assign cmd_flag = w_data[BPI_CMD_FLAG_LSB +: 2];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= BPI_RESP_OKAY;
            ctrl <= BPI_CTRL_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                w_data <= s_axi_wdata;
            end
            if (aw_got && w_got && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= BPI_RESP_OKAY;
                if (aw_addr == BPI_OFS_CTRL) begin
                    if (s_axi_wstrb[0]) ctrl[7:0] <= w_data[7:0];
                end else if (aw_addr != BPI_OFS_CMD) begin
                    s_axi_bresp <= BPI_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got <= 1'b0;
                w_got <= 1'b0;
            end
        end
    end

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= BPI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= BPI_RESP_OKAY;
            unique case (s_axi_araddr)
                BPI_OFS_CTRL: s_axi_rdata <= ctrl;
                BPI_OFS_STAT: s_axi_rdata <= {22'h0, state, inhibit_s,
                    true_s, input_ready_n_o, label_a_hold, flags};
                BPI_OFS_CMD: s_axi_rdata <= 32'h0000_0000;
                BPI_OFS_DIGIT: s_axi_rdata <= {24'h0, cur.kind, cur.value};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= BPI_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : bpi_port
`default_nettype wire

// >>> tb/bpi_periph.sv
`timescale 1ns/1ps
`default_nettype none
module bpi_periph (
    input wire logic clk_i,
    input wire logic ready_n_i,
    output logic [39:0] data_o,
    output logic load_o,
    output logic load_n_o
);
    // released data and load_n_o lines float to the pull-up level; load_o rests low
    initial begin
        data_o = '1;
        load_o = 1'b0;
        load_n_o = 1'b1;
    end
    task automatic send(input logic [39:0] d, input logic use_n);
        do begin
            @(negedge clk_i);
        end while (ready_n_i);
        @(posedge clk_i);
        data_o <= d;
        if (use_n) load_n_o <= 1'b0;
        else load_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        load_o <= 1'b0;
        load_n_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        data_o <= '1;
    endtask : send
endmodule : bpi_periph
`default_nettype wire

// >>> tb/bpi_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bpi_port_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic inhibit_i,
    input wire logic load_i,
    input wire logic load_n_i,
    input wire logic flag_out_zero_n_o,
    input wire logic flag_out_one_n_o,
    input wire logic flag_out_two_n_o,
    input wire logic flag_out_three_n_o,
    input wire logic input_ready_n_o,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire [3:0] fl = {flag_out_three_n_o, flag_out_two_n_o,
        flag_out_one_n_o, flag_out_zero_n_o};
    sequence s_busy;
        input_ready_n_o [*8];
    endsequence
    a_reset_ready_low: assert property ($fell(rst_i) |-> !input_ready_n_o)
        else $error("ready not low after reset");
    a_reset_flags_off: assert property ($fell(rst_i) |-> fl == 4'hF)
        else $error("flag outputs active after reset");
    a_inhibit_flags_off: assert property (inhibit_i [*5] |-> fl == 4'hF)
        else $error("flag output active while inhibited");
    a_ready_busy_hold: assert property (
        ($rose(load_i) || $fell(load_n_i)) && !input_ready_n_o
        && !inhibit_i |-> ##4 s_busy)
        else $error("ready dropped before digits consumed");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read response late");
    a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("write response withdrawn");
    a_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response withdrawn");
endmodule : bpi_port_chk
bind bpi_port bpi_port_chk i_bpi_port_chk (.clk_i, .rst_i, .inhibit_i,
    .load_i, .load_n_i,
    .flag_out_zero_n_o, .flag_out_one_n_o, .flag_out_two_n_o,
    .flag_out_three_n_o, .input_ready_n_o, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata);
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import bpi_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, tm = 1'b1, inh = 1'b0, key = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, rdy_n, ld, ld_n;
    logic [1:0] bresp, rresp, rs, ws;
    logic [39:0] data;
    logic [3:0] fl;
    int fails = 0, tests_run = 0;
    always #10 clk_i = ~clk_i;
    bpi_periph i_bpi_periph (.clk_i(clk_i), .ready_n_i(rdy_n), .data_o(data),
        .load_o(ld), .load_n_o(ld_n));
    bpi_port i_bpi_port (.clk_i(clk_i), .rst_i(rst_i), .data_i(data),
        .true_mode_i(tm), .load_i(ld), .load_n_i(ld_n), .inhibit_i(inh),
        .key_entry_i(key), .flag_out_zero_n_o(fl[0]),
        .flag_out_one_n_o(fl[1]), .flag_out_two_n_o(fl[2]),
        .flag_out_three_n_o(fl[3]), .input_ready_n_o(rdy_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b, h;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge clk_i);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            h = bvalid && bready;
            if (h) ws = bresp;
            @(posedge clk_i);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            bready <= b && !h;
        end while (!h);
    endtask : axw
    task automatic axr(input logic [7:0] a);
        logic ar, v, h;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge clk_i);
            ar = arvalid && arready;
            v = rvalid;
            h = rvalid && rready;
            if (h) rd = rdata;
            if (h) rs = rresp;
            @(posedge clk_i);
            if (ar) arvalid <= 1'b0;
            rready <= v && !h;
        end while (!h);
    endtask : axr
    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask : wt
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done
    initial begin
        #1ms;
        fails++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wt(1);
        chk(fl, 4'hF);
        chk(rdy_n, 1'b0);
        for (int i = 0; i < 4; i++) begin
            axw(BPI_OFS_CMD, 32'h01 | (i << 4));
            wt(3);
            chk(fl, 4'(~(4'h1 << i)));
            axw(BPI_OFS_CMD, 32'h03 | (i << 4));
            wt(3);
            chk(fl, i >= 2 ? 4'hF : 4'(~(4'h1 << i)));
            axw(BPI_OFS_CMD, 32'h02 | (i << 4));
            wt(3);
            chk(fl, 4'hF);
        end
        axw(BPI_OFS_CMD, 32'h11);
        chk(ws, BPI_RESP_OKAY);
        @(posedge clk_i) inh <= 1'b1;
        wt(8);
        chk(fl, 4'hF);
        axr(BPI_OFS_STAT);
        chk(rd[3:0], 4'h2);
        @(posedge clk_i) inh <= 1'b0;
        axw(BPI_OFS_CMD, 32'h01);
        wt(3);
        chk(fl, 4'hC);
        axw(BPI_OFS_CMD, 32'h02);
        axw(BPI_OFS_CMD, 32'h12);
        axw(BPI_OFS_CTRL, 32'h1);
        wt(3);
        chk(rdy_n, 1'b1);
        axw(BPI_OFS_CTRL, 32'h0);
        wt(3);
        chk(rdy_n, 1'b0);
        axr(8'h40);
        chk(rs, BPI_RESP_SLVERR);
        axw(8'h40, 32'h0);
        chk(ws, BPI_RESP_SLVERR);
        @(posedge clk_i) key <= 1'b1;
        @(posedge clk_i) key <= 1'b0;
        wt(10);
        chk(fl[3], 1'b0);
        axw(BPI_OFS_CMD, 32'h32);
        for (int c = 0; c < 16; c++) begin
            @(posedge clk_i) tm <= c[0];
            i_bpi_periph.send({36'hF_FFFF_FFFF, c[3:0]} ^ {40{~c[0]}}, c[1]);
            wt(20);
            axr(BPI_OFS_STAT);
            chk(rd[3], c <= 11);
            axw(BPI_OFS_CMD, 32'h32);
            wt(3);
            chk(rdy_n, 1'b0);
        end
        @(posedge clk_i) tm <= 1'b1;
        i_bpi_periph.send({4'h1, 4'hD, 32'hFFFF_FFFF}, 1'b0);
        wt(30);
        chk(rdy_n, 1'b1);
        axr(BPI_OFS_STAT);
        chk(rd[4], 1'b1);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
